// ===== rtl/otgr_regbank.sv
`timescale 1ns/100ps
`default_nettype none

module otgr_regbank #(
    parameter logic [15:0] MAKER_IDENTITY = 16'h1357, // arbitrary value
    parameter logic [15:0] PART_IDENTITY  = 16'h2468, // arbitrary value
    parameter logic        PART_VARIANT   = 1'b0
) (
    input  wire logic                        i_core_clk,
    input  wire logic                        i_rst,
    input  wire logic                        i_scl,
    input  wire logic                        i_sda,
    output logic                             o_sda_out,
    output logic                             o_sda_oe_n,
    input  wire logic                        i_address_select_pin,
    input  wire otgr_pkg::otgr_byte_t        i_line_status,
    input  wire logic                        i_line_se0,
    input  wire logic [otgr_pkg::GPIO_W-1:0] i_gpio,
    output logic      [otgr_pkg::GPIO_W-1:0] o_gpio_out,
    output logic      [otgr_pkg::GPIO_W-1:0] o_gpio_oe_n,
    input  wire logic                        i_uart2_txd,
    output logic                             o_uart2_rxd,
    input  wire logic                        i_oe_int_pin,
    output logic                             o_oe_int_out,
    output logic                             o_oe_int_oe_n,
    output logic                             o_sie_oe_n,
    output logic                             o_int_out,
    output logic                             o_int_oe_n,
    output logic                             o_full_speed,
    output logic                             o_low_power,
    output logic                             o_combined_signalling_select,
    output logic                             o_uart_mode,
    output logic                             o_uart2_route,
    output otgr_pkg::otgr_byte_t             o_termination_ctrl,
    output otgr_pkg::otgr_byte_t             o_power_misc_ctrl
);
    import otgr_pkg::*;

    logic        scl_q_r;
    logic        sda_q_r;
    logic        scl_rise;
    logic        scl_fall;
    logic        bus_start;
    logic        bus_stop;
    logic [6:0]  dev_addr;

    otgr_state_t state_r;
    logic [3:0]  cnt_r;
    otgr_byte_t  shift_r;
    otgr_byte_t  ptr_r;
    logic        rw_r;
    logic        nack_r;
    logic        wr_stb_r;
    otgr_byte_t  wr_addr_r;
    otgr_byte_t  wr_data_r;

    otgr_byte_t  sc_q      [NUM_SC];
    otgr_byte_t  hw_set_v  [NUM_SC];
    otgr_byte_t  cr1;
    otgr_byte_t  cr3;
    otgr_byte_t  src_now;
    otgr_byte_t  src_q_r;
    otgr_byte_t  src_edges;
    logic [GPIO_W-1:0] gpio_q_r;
    logic [GPIO_W-1:0] gpio_edges;
    logic        primed_r;
    logic        acon_r;
    logic        acon_evt;
    logic        pending;
    logic        pending_r;
    logic        oe_int_drive_r;

    // bus lines are taken as synchronous; one stage of history finds edges
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            scl_q_r <= 1'b1;
            sda_q_r <= 1'b1;
        end else begin
            scl_q_r <= i_scl;
            sda_q_r <= i_sda;
        end
    end

    assign scl_rise  = i_scl & ~scl_q_r;
    assign scl_fall  = ~i_scl & scl_q_r;
    assign bus_start = i_scl & scl_q_r & sda_q_r & ~i_sda;
    assign bus_stop  = i_scl & scl_q_r & ~sda_q_r & i_sda;
    assign dev_addr  = {DEV_ADDR_HI, PART_VARIANT, i_address_select_pin};

    assign cr1 = sc_q[IX_CR1];
    assign cr3 = sc_q[IX_CR3];

    // bit 6 shows the comparator only while automation is off
    always_comb begin
        src_now = i_line_status;
        if (!(cr3[CR3_SESSEN] && !cr1[CR1_BDIS])) begin
            src_now[SRC_BDIS] = acon_r;
        end
    end

    function automatic otgr_byte_t rd_byte(input otgr_byte_t a);
        otgr_byte_t v;
        v = 8'h00;
        case (a)
            A_MAKER_LO: v = MAKER_IDENTITY[7:0];
            A_MAKER_HI: v = MAKER_IDENTITY[15:8];
            A_PART_LO:  v = PART_IDENTITY[7:0];
            A_PART_HI:  v = PART_IDENTITY[15:8];
            A_INT_SRC:  v = src_now;
            A_GPIO_IN:  v = {{(BYTE_BITS-GPIO_W){1'b0}}, i_gpio};
            default:    v = 8'h00;
        endcase
        for (int k = 0; k < NUM_SC; k++) begin
            if (a[7:1] == SC_BASE[k][7:1]) begin
                v = sc_q[k];
            end
        end
        return v;
    endfunction

    // serial engine: data sampled on scl rise, sda changed after scl fall
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            state_r   <= ST_IDLE;
            cnt_r     <= 4'h0;
            shift_r   <= 8'h00;
            ptr_r     <= 8'h00;
            rw_r      <= 1'b0;
            nack_r    <= 1'b0;
            wr_stb_r  <= 1'b0;
            wr_addr_r <= 8'h00;
            wr_data_r <= 8'h00;
        end else begin
            wr_stb_r <= 1'b0;
            if (bus_start) begin
                state_r <= ST_ADDR;
                cnt_r   <= 4'h0;
            end else if (bus_stop) begin
                state_r <= ST_IDLE;
            end else begin
                case (state_r)
                    ST_IDLE: begin
                        cnt_r <= 4'h0;
                    end
                    ST_ADDR, ST_REG, ST_WDATA: begin
                        if (scl_rise) begin
                            shift_r <= {shift_r[6:0], i_sda};
                            cnt_r   <= cnt_r + 4'h1;
                        end else if (scl_fall && cnt_r == 4'h8) begin
                            cnt_r <= 4'h0;
                            if (state_r == ST_ADDR) begin
                                if (shift_r[7:1] == dev_addr) begin
                                    state_r <= ST_ADDR_ACK;
                                    rw_r    <= shift_r[0];
                                end else begin
                                    state_r <= ST_IDLE;
                                end
                            end else if (state_r == ST_REG) begin
                                state_r <= ST_REG_ACK;
                                ptr_r   <= shift_r;
                            end else begin
                                state_r   <= ST_WDATA_ACK;
                                wr_stb_r  <= 1'b1;
                                wr_addr_r <= ptr_r;
                                wr_data_r <= shift_r;
                            end
                        end
                    end
                    ST_ADDR_ACK: begin
                        if (scl_fall) begin
                            cnt_r <= 4'h0;
                            if (rw_r) begin
                                state_r <= ST_RDATA;
                                shift_r <= rd_byte(ptr_r);
                            end else begin
                                state_r <= ST_REG;
                            end
                        end
                    end
                    ST_REG_ACK: begin
                        if (scl_fall) begin
                            state_r <= ST_WDATA;
                        end
                    end
                    ST_WDATA_ACK: begin
                        if (scl_fall) begin
                            state_r <= ST_WDATA;
                            ptr_r   <= ptr_r + 8'h01;
                        end
                    end
                    ST_RDATA: begin
                        if (scl_rise) begin
                            cnt_r <= cnt_r + 4'h1;
                        end else if (scl_fall) begin
                            if (cnt_r == 4'h8) begin
                                state_r <= ST_RDATA_ACK;
                            end else begin
                                shift_r <= {shift_r[6:0], 1'b0};
                            end
                        end
                    end
                    ST_RDATA_ACK: begin
                        if (scl_rise) begin
                            nack_r <= i_sda;
                        end else if (scl_fall) begin
                            cnt_r <= 4'h0;
                            if (nack_r) begin
                                state_r <= ST_IDLE;
                            end else begin
                                state_r <= ST_RDATA;
                                ptr_r   <= ptr_r + 8'h01;
                                shift_r <= rd_byte(ptr_r + 8'h01);
                            end
                        end
                    end
                    default: begin
                        state_r <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    assign o_sda_out  = 1'b0;
    assign o_sda_oe_n = ~((state_r == ST_ADDR_ACK) || (state_r == ST_REG_ACK) || (state_r == ST_WDATA_ACK)
                          || ((state_r == ST_RDATA) && !shift_r[7]));

    // automatic connect: held until automation is switched off
    always_ff @(posedge i_core_clk) begin
        if (i_rst || !cr1[CR1_BDIS]) begin
            acon_r <= 1'b0;
        end else if (i_line_se0) begin
            acon_r <= 1'b1;
        end
    end

    assign acon_evt = cr1[CR1_BDIS] & i_line_se0 & ~acon_r;

    // history for edge-triggered latches; first cycle after reset sees no edge
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            primed_r <= 1'b0;
            src_q_r  <= 8'h00;
            gpio_q_r <= '0;
        end else begin
            primed_r <= 1'b1;
            src_q_r  <= src_now;
            gpio_q_r <= i_gpio;
        end
    end

    assign src_edges  = primed_r ? ((src_now & ~src_q_r & sc_q[IX_MT]) | (~src_now & src_q_r & sc_q[IX_MF]))
                                 : 8'h00;
    assign gpio_edges = primed_r ? ((i_gpio & ~gpio_q_r & sc_q[IX_GMT][GPIO_W-1:0])
                                   | (~i_gpio & gpio_q_r & sc_q[IX_GMF][GPIO_W-1:0]))
                                 : '0;

    always_comb begin
        for (int k = 0; k < NUM_SC; k++) begin
            hw_set_v[k] = 8'h00;
        end
        hw_set_v[IX_LATCH] = src_edges | (acon_evt ? 8'h40 : 8'h00);
        hw_set_v[IX_GINT]  = {{(BYTE_BITS-GPIO_W){1'b0}}, gpio_edges};
    end

    // only pair addresses reach storage; anything else falls through
    for (genvar g = 0; g < NUM_SC; g++) begin : g_sc
        otgr_sc_if sc_if ();

        assign sc_if.wdata  = wr_data_r;
        assign sc_if.set_we = wr_stb_r && (wr_addr_r[7:1] == SC_BASE[g][7:1]) && !wr_addr_r[0];
        assign sc_if.clr_we = wr_stb_r && (wr_addr_r[7:1] == SC_BASE[g][7:1]) && wr_addr_r[0];
        assign sc_if.hw_set = hw_set_v[g];
        assign sc_q[g]      = sc_if.q;

        otgr_setclr_reg #(
            .RST_VAL (SC_RST[g]),
            .KEEP    (SC_KEEP[g])
        ) u_reg (
            .i_core_clk (i_core_clk),
            .i_rst      (i_rst),
            .bus        (sc_if.store)
        );
    end

    assign pending = (|sc_q[IX_LATCH]) | (|sc_q[IX_GINT]);

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            pending_r      <= 1'b0;
            oe_int_drive_r <= 1'b0;
        end else begin
            pending_r      <= pending;
            oe_int_drive_r <= cr1[CR1_OEINT] & cr1[CR1_SUSPEND] & pending;
        end
    end

    assign o_int_out     = 1'b0;
    assign o_int_oe_n    = ~pending_r;
    assign o_oe_int_out  = 1'b0;
    assign o_oe_int_oe_n = ~oe_int_drive_r;
    // pin level passes to the serial engine side only while not driven
    assign o_sie_oe_n    = oe_int_drive_r ? 1'b1 : i_oe_int_pin;

    // open-drain gpio: only a low is ever driven
    for (genvar b = 0; b < GPIO_W; b++) begin : g_gpio
        logic drive_r;
        always_ff @(posedge i_core_clk) begin
            if (i_rst) begin
                drive_r <= 1'b0;
            end else if (cr1[CR1_UARTIO] && b == GPIO_TX) begin
                drive_r <= ~i_uart2_txd;
            end else if (cr1[CR1_UARTIO] && b == GPIO_RX) begin
                drive_r <= 1'b0;
            end else begin
                drive_r <= sc_q[IX_GOE][b] & ~sc_q[IX_GOUT][b];
            end
        end
        assign o_gpio_out[b]  = 1'b0;
        assign o_gpio_oe_n[b] = ~drive_r;
    end

    assign o_uart2_rxd                  = cr1[CR1_UARTIO] ? i_gpio[GPIO_RX] : 1'b1;
    assign o_uart2_route                = cr1[CR1_UARTIO];
    assign o_full_speed                 = cr1[CR1_SPEED];
    assign o_low_power                  = cr1[CR1_SUSPEND];
    assign o_combined_signalling_select = cr1[CR1_DATSE0];
    assign o_uart_mode                  = cr1[CR1_UART];
    // all bits of cr2 and cr3, unassigned ones too, are stored and driven out
    assign o_termination_ctrl = sc_q[IX_CR2] | {7'h00, acon_r};
    assign o_power_misc_ctrl  = cr3;

endmodule // otgr_regbank

`default_nettype wire

// ===== rtl/otgr_pkg.sv
// Function
// - set address writes ones into register bits
// - clear address writes ones clear register bits
// - both addresses read same register contents
// - reset clears bits except listed reset-one subset; SC_RST here clears every bit to zero
// - unassigned bit positions are undefined for software
// - gpio registers read zero in upper five bits
// - read-only maker identity at 00h/01h, low first
// - read-only part identity at 02h/03h, low first
// - part identity is a build-time constant
// - control bit 0 selects low or full speed
// - control bit 2 selects split or combined signalling
// - bit 4: se0 connects d+ pull-up, flags interrupt
// - bit 5 with low power drives int pin low while an interrupt is pending
// - control bit 6 selects usb or uart mode
// - bit 7 routes gpio 0/1 to second uart
// - bus address 01011, variant bit, select pin
// - source bit 6 shows session end when enabled; with control bit 4 set it shows the automatic connect state
`default_nettype none

package otgr_pkg;

    typedef logic [7:0] otgr_byte_t;

    localparam int GPIO_W = 3;
    localparam int BYTE_BITS = 8;

    localparam logic [4:0] DEV_ADDR_HI = 5'h0B;

    localparam otgr_byte_t A_MAKER_LO = 8'h00;
    localparam otgr_byte_t A_MAKER_HI = 8'h01;
    localparam otgr_byte_t A_PART_LO  = 8'h02;
    localparam otgr_byte_t A_PART_HI  = 8'h03;
    localparam otgr_byte_t A_INT_SRC  = 8'h08;
    localparam otgr_byte_t A_GPIO_IN  = 8'h18;

    // set/clear pairs: set at the even base, clear at base + 1
    localparam int NUM_SC   = 11;
    localparam int IX_CR1   = 0;
    localparam int IX_CR2   = 1;
    localparam int IX_LATCH = 2;
    localparam int IX_MF    = 3;
    localparam int IX_MT    = 4;
    localparam int IX_CR3   = 5;
    localparam int IX_GOE   = 6;
    localparam int IX_GOUT  = 7;
    localparam int IX_GINT  = 8;
    localparam int IX_GMF   = 9;
    localparam int IX_GMT   = 10;

    localparam otgr_byte_t SC_BASE [NUM_SC] = '{8'h04, 8'h06, 8'h0A, 8'h0C, 8'h0E, 8'h12,
                                                8'h14, 8'h16, 8'h1A, 8'h1C, 8'h1E};
    localparam otgr_byte_t SC_KEEP [NUM_SC] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
                                                8'h07, 8'h07, 8'h07, 8'h07, 8'h07};
    localparam otgr_byte_t SC_RST  [NUM_SC] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
                                                8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

    localparam int CR1_SPEED   = 0;
    localparam int CR1_SUSPEND = 1;
    localparam int CR1_DATSE0  = 2;
    localparam int CR1_BDIS    = 4;
    localparam int CR1_OEINT   = 5;
    localparam int CR1_UART    = 6;
    localparam int CR1_UARTIO  = 7;
    localparam int CR2_DP_PU   = 0;
    localparam int CR3_SESSEN  = 4;
    localparam int SRC_BDIS    = 6;
    localparam int GPIO_RX     = 0;
    localparam int GPIO_TX     = 1;

    typedef enum logic [8:0] {
        ST_IDLE      = 9'h001,
        ST_ADDR      = 9'h002,
        ST_ADDR_ACK  = 9'h004,
        ST_REG       = 9'h008,
        ST_REG_ACK   = 9'h010,
        ST_WDATA     = 9'h020,
        ST_WDATA_ACK = 9'h040,
        ST_RDATA     = 9'h080,
        ST_RDATA_ACK = 9'h100
    } otgr_state_t;

endpackage

`default_nettype wire

// ===== rtl/otgr_sc_if.sv
`timescale 1ns/100ps
`default_nettype none

interface otgr_sc_if;
    logic [7:0] wdata;
    logic       set_we;
    logic       clr_we;
    logic [7:0] hw_set;
    logic [7:0] q;

    modport ctl   (output wdata, output set_we, output clr_we, output hw_set, input q);
    modport store (input wdata, input set_we, input clr_we, input hw_set, output q);
endinterface

`default_nettype wire

// ===== rtl/otgr_setclr_reg.sv
`timescale 1ns/100ps
`default_nettype none

module otgr_setclr_reg #(
    parameter logic [7:0] RST_VAL = 8'h00,
    parameter logic [7:0] KEEP    = 8'hFF
) (
    input  wire logic i_core_clk,
    input  wire logic i_rst,
    otgr_sc_if.store  bus
);
    logic [7:0] q_r;
    logic [7:0] q_nxt;

    // hardware set is applied after the clear so an event is never lost
    always_comb begin
        q_nxt = q_r;
        if (bus.clr_we) begin
            q_nxt = q_nxt & ~bus.wdata;
        end
        if (bus.set_we) begin
            q_nxt = q_nxt | bus.wdata;
        end
        q_nxt = (q_nxt | bus.hw_set) & KEEP;
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            q_r <= RST_VAL;
        end else begin
            q_r <= q_nxt;
        end
    end

    assign bus.q = q_r;

endmodule // otgr_setclr_reg

`default_nettype wire

// ===== dv/otgr_checker.sv
`timescale 1ns/100ps
`default_nettype none

module otgr_checker (
    input wire logic                        i_core_clk,
    input wire logic                        i_rst,
    input wire logic                        i_scl,
    input wire logic [otgr_pkg::GPIO_W-1:0] i_gpio,
    input wire logic                        i_oe_int_pin,
    input wire logic                        o_sda_oe_n,
    input wire logic                        o_oe_int_oe_n,
    input wire logic                        o_sie_oe_n,
    input wire logic                        o_full_speed,
    input wire logic                        o_low_power,
    input wire logic                        o_combined_signalling_select,
    input wire logic                        o_uart_mode,
    input wire logic                        o_uart2_route,
    input wire logic                        o_uart2_rxd,
    input wire otgr_pkg::otgr_byte_t        o_power_misc_ctrl
);
    import otgr_pkg::*;

    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (i_rst);

    // the device may only move sda or its controls while scl is low
    sequence s_scl_low;
        !i_scl;
    endsequence
    sequence s_ctl_move;
        $changed({o_full_speed, o_low_power, o_combined_signalling_select, o_uart_mode, o_uart2_route});
    endsequence

    property p_reset_ctrl;
        $fell(i_rst) |-> !o_full_speed && !o_low_power && !o_uart_mode && !o_uart2_route
            && o_sda_oe_n && o_oe_int_oe_n && o_power_misc_ctrl == 8'h00;
    endproperty
    property p_ctrl_scl_low;
        s_ctl_move |-> s_scl_low;
    endproperty
    property p_pm_scl_low;
        $changed(o_power_misc_ctrl) |-> s_scl_low;
    endproperty
    property p_ack_scl_low;
        $fell(o_sda_oe_n) |-> s_scl_low;
    endproperty
    property p_rel_scl_low;
        $rose(o_sda_oe_n) |-> s_scl_low;
    endproperty
    property p_oeint_lowpwr;
        !o_oe_int_oe_n |-> o_low_power || $past(o_low_power);
    endproperty
    property p_sie_pass;
        o_sie_oe_n == (o_oe_int_oe_n ? i_oe_int_pin : 1'b1);
    endproperty
    property p_uart2_rx;
        o_uart2_route && $past(o_uart2_route) && $stable(i_gpio) |-> o_uart2_rxd == i_gpio[0];
    endproperty
    property p_uart2_idle;
        !o_uart2_route && !$past(o_uart2_route) |-> o_uart2_rxd;
    endproperty

    a_reset_ctrl: assert property (p_reset_ctrl) else $error("controls not idle after reset");
    a_ctrl_scl_low: assert property (p_ctrl_scl_low) else $error("control moved with scl high");
    a_pm_scl_low: assert property (p_pm_scl_low) else $error("power control moved with scl high");
    a_ack_scl_low: assert property (p_ack_scl_low) else $error("sda pulled with scl high");
    a_rel_scl_low: assert property (p_rel_scl_low) else $error("sda released with scl high");
    a_oeint_lowpwr: assert property (p_oeint_lowpwr) else $error("int pin driven at full power");
    a_sie_pass: assert property (p_sie_pass) else $error("sie enable wrong");
    a_uart2_rx: assert property (p_uart2_rx) else $error("second uart rx not gpio0");
    a_uart2_idle: assert property (p_uart2_idle) else $error("second uart rx not idle");

endmodule // otgr_checker

bind otgr_regbank otgr_checker i_otgr_checker (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_scl(i_scl),
    .i_gpio(i_gpio), .i_oe_int_pin(i_oe_int_pin), .o_sda_oe_n(o_sda_oe_n), .o_oe_int_oe_n(o_oe_int_oe_n),
    .o_sie_oe_n(o_sie_oe_n), .o_full_speed(o_full_speed), .o_low_power(o_low_power),
    .o_combined_signalling_select(o_combined_signalling_select), .o_uart_mode(o_uart_mode),
    .o_uart2_route(o_uart2_route), .o_uart2_rxd(o_uart2_rxd), .o_power_misc_ctrl(o_power_misc_ctrl));

`default_nettype wire

// ===== dv/otgr_host_model.sv
`timescale 1ns/100ps
`default_nettype none

module otgr_host_model (
    input  wire logic i_core_clk,
    input  wire logic i_sda_line,
    output var logic  o_scl,
    output var logic  o_sda
);
    import otgr_pkg::*;

    initial begin
        o_scl = 1'b1;
        o_sda = 1'b1;
    end
    // three clocks a phase, so every scl level is seen more than once
    task automatic wt();
        repeat (3) @(posedge i_core_clk);
    endtask
    task automatic start();
        o_sda <= 1'b1;
        wt();
        o_scl <= 1'b1;
        wt();
        o_sda <= 1'b0;
        wt();
        o_scl <= 1'b0;
        wt();
    endtask
    task automatic stop();
        o_sda <= 1'b0;
        wt();
        o_scl <= 1'b1;
        wt();
        o_sda <= 1'b1;
        wt();
    endtask
    task automatic put_bit(input logic b);
        o_sda <= b;
        wt();
        o_scl <= 1'b1;
        wt();
        o_scl <= 1'b0;
        wt();
    endtask
    task automatic get_bit(output logic b);
        o_sda <= 1'b1;
        wt();
        o_scl <= 1'b1;
        wt();
        b = i_sda_line;
        o_scl <= 1'b0;
        wt();
    endtask
    task automatic put_byte(input otgr_byte_t d, output logic ack);
        logic b;
        for (int i = 7; i >= 0; i--) begin
            put_bit(d[i]);
        end
        get_bit(b);
        ack = ~b;
    endtask
    task automatic get_byte(output otgr_byte_t d);
        for (int i = 7; i >= 0; i--) begin
            get_bit(d[i]);
        end
        put_bit(1'b1);
    endtask
    task automatic xfer_write(input logic [6:0] dev, input otgr_byte_t ra, input otgr_byte_t d, output logic ack);
        logic a0, a1, a2;
        start();
        put_byte({dev, 1'b0}, a0);
        put_byte(ra, a1);
        put_byte(d, a2);
        stop();
        ack = a0 & a1 & a2;
    endtask
    task automatic xfer_read(input logic [6:0] dev, input otgr_byte_t ra, output otgr_byte_t d, output logic ack);
        logic a0, a1, a2;
        start();
        put_byte({dev, 1'b0}, a0);
        put_byte(ra, a1);
        start();
        put_byte({dev, 1'b1}, a2);
        get_byte(d);
        stop();
        ack = a0 & a1 & a2;
    endtask

endmodule // otgr_host_model

`default_nettype wire

// ===== dv/test_otg_phy_set_clear_regs.sv
`timescale 1ns/100ps
`default_nettype none

module test_otg_phy_set_clear_regs;
    import otgr_pkg::*;

    logic              clk, rst, addr_sel, se0, txd, oe_int_pin;
    logic              sda_out, sda_oe_n, uart2_rxd, oe_int_oe_n, sie_oe_n, int_oe_n;
    logic              full_speed, low_power, comb_sel, uart_mode, uart2_route;
    logic [GPIO_W-1:0] gpio, gpio_oe_n;
    otgr_byte_t        line_status, term_ctrl, pm_ctrl;
    wire logic         scl, host_sda, sda_line;
    logic [6:0]        dev;
    int                num_errors, num_checks;

    // open drain line with pull-up
    assign sda_line = host_sda & (sda_oe_n | sda_out);

    otgr_host_model i_otgr_host_model (.i_core_clk(clk), .i_sda_line(sda_line), .o_scl(scl), .o_sda(host_sda));

    otgr_regbank i_otgr_regbank (.i_core_clk(clk), .i_rst(rst), .i_scl(scl), .i_sda(sda_line),
        .o_sda_out(sda_out), .o_sda_oe_n(sda_oe_n), .i_address_select_pin(addr_sel),
        .i_line_status(line_status), .i_line_se0(se0), .i_gpio(gpio), .o_gpio_out(), .o_gpio_oe_n(gpio_oe_n),
        .i_uart2_txd(txd), .o_uart2_rxd(uart2_rxd), .i_oe_int_pin(oe_int_pin), .o_oe_int_out(),
        .o_oe_int_oe_n(oe_int_oe_n), .o_sie_oe_n(sie_oe_n), .o_int_out(), .o_int_oe_n(int_oe_n),
        .o_full_speed(full_speed), .o_low_power(low_power), .o_combined_signalling_select(comb_sel),
        .o_uart_mode(uart_mode), .o_uart2_route(uart2_route), .o_termination_ctrl(term_ctrl),
        .o_power_misc_ctrl(pm_ctrl));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic chk(input otgr_byte_t got, input otgr_byte_t exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input otgr_byte_t a, input otgr_byte_t d);
        logic ack;
        i_otgr_host_model.xfer_write(dev, a, d, ack);
        chk({7'h00, ack}, 8'h01);
    endtask
    task automatic rd(input otgr_byte_t a, input otgr_byte_t exp);
        logic       ack;
        otgr_byte_t got;
        i_otgr_host_model.xfer_read(dev, a, got, ack);
        chk({7'h00, ack}, 8'h01);
        chk(got, exp);
    endtask
    task automatic settle();
        repeat (4) @(posedge clk);
    endtask
    function automatic otgr_byte_t ctl();
        return {uart2_route, uart_mode, 3'h0, comb_sel, low_power, full_speed};
    endfunction
    function automatic otgr_byte_t pins();
        return {4'h0, term_ctrl[0], int_oe_n, oe_int_oe_n, sie_oe_n};
    endfunction

    task automatic t_ident();
        rd(8'h00, 8'h57);
        rd(8'h01, 8'h13);
        rd(8'h02, 8'h68);
        rd(8'h03, 8'h24);
        rd(8'h04, 8'h00);
        rd(8'h06, 8'h00);
        wr(8'h00, 8'hFF);
        wr(8'h03, 8'h00);
        rd(8'h00, 8'h57);
        rd(8'h03, 8'h24);
        $display("t_ident done");
    endtask
    task automatic t_setclr();
        wr(8'h04, 8'hC7);
        rd(8'h05, 8'hC7);
        chk(ctl(), 8'hC7);
        wr(8'h05, 8'h85);
        rd(8'h04, 8'h42);
        chk(ctl(), 8'h42);
        wr(8'h05, 8'hFF);
        chk(ctl(), 8'h00);
        $display("t_setclr done");
    endtask
    task automatic t_gpio();
        wr(8'h14, 8'hFF);
        rd(8'h15, 8'h07);
        wr(8'h15, 8'hFF);
        gpio <= 3'h5;
        rd(8'h18, 8'h05);
        $display("t_gpio done");
    endtask
    task automatic t_route();
        wr(8'h04, 8'h80);
        gpio <= 3'h1;
        txd <= 1'b0;
        settle();
        chk({6'h0, gpio_oe_n[1], uart2_rxd}, 8'h01);
        gpio <= 3'h0;
        txd <= 1'b1;
        settle();
        chk({6'h0, gpio_oe_n[1], uart2_rxd}, 8'h02);
        wr(8'h05, 8'h80);
        chk({7'h0, uart2_rxd}, 8'h01);
        $display("t_route done");
    endtask
    task automatic t_autocon();
        oe_int_pin <= 1'b0;
        wr(8'h04, 8'h32);
        se0 <= 1'b1;
        settle();
        chk(pins(), 8'h09);
        se0 <= 1'b0;
        wr(8'h05, 8'h02);
        chk(pins(), 8'h0A);
        wr(8'h0B, 8'hFF);
        wr(8'h05, 8'h30);
        chk(pins(), 8'h06);
        oe_int_pin <= 1'b1;
        $display("t_autocon done");
    endtask
    task automatic t_sessend();
        wr(8'h12, 8'h10);
        chk(pm_ctrl, 8'h10);
        line_status <= 8'h41;
        rd(8'h08, 8'h41);
        line_status <= 8'h01;
        rd(8'h08, 8'h01);
        wr(8'h13, 8'h10);
        line_status <= 8'h41;
        rd(8'h08, 8'h01);
        $display("t_sessend done");
    endtask
    task automatic t_addr();
        logic ack;
        i_otgr_host_model.xfer_write(7'h2D, 8'h04, 8'hFF, ack);
        chk({7'h00, ack}, 8'h00);
        rd(8'h04, 8'h00);
        addr_sel <= 1'b1;
        dev = 7'h2D;
        rd(8'h00, 8'h57);
        addr_sel <= 1'b0;
        dev = 7'h2C;
        $display("t_addr done");
    endtask

    task automatic summarize();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        num_errors = 0;
        num_checks = 0;
        dev = {DEV_ADDR_HI, 1'b0, 1'b0};
        rst = 1'b1;
        addr_sel = 1'b0;
        se0 = 1'b0;
        txd = 1'b1;
        oe_int_pin = 1'b1;
        line_status = 8'h00;
        gpio = 3'h0;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_ident();
        t_setclr();
        t_gpio();
        t_route();
        t_autocon();
        t_sessend();
        t_addr();
        summarize();
    end

endmodule // test_otg_phy_set_clear_regs

`default_nettype wire
